// *** hdl/dcc_pkg.sv ***
`default_nettype none
package dcc_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_RESP     = 8'h04;
  localparam logic [7:0] REG_STAT     = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_IP       = 8'h14;
  localparam logic [7:0] REG_CUR      = 8'h18;
  localparam logic [7:0] REG_PC       = 8'h1C;
  localparam logic [7:0] REG_DATA     = 8'h20;
  localparam logic [7:0] DATA_MASK    = 8'hE3;
  localparam int         N_DREG       = 8;
  // Command word layout and codes
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_HAS_BIT  = 3;
  localparam int CMD_P1_LSB   = 8;
  localparam int CMD_P2_LSB   = 16;
  localparam logic [2:0] CMD_SEC  = 3'h1;
  localparam logic [2:0] CMD_PRI  = 3'h2;
  localparam logic [2:0] CMD_NODE = 3'h3;
  localparam logic [2:0] CMD_PEAK = 3'h4;
  localparam logic [2:0] CMD_CONT = 3'h5;
  localparam logic [2:0] CMD_CMP  = 3'h6;
  localparam logic [2:0] CMD_JUMP = 3'h7;
  localparam logic [7:0] RESP_EQ  = 8'h3D;
  // Mode codes
  localparam logic [7:0] MODE_MIN      = 8'h01;
  localparam logic [7:0] MODE_MAX      = 8'h16;
  localparam logic [4:0] SEC_MODE_RST  = 5'h07;
  localparam logic [4:0] PRI_MODE_RST  = 5'h07;
  localparam logic [4:0] STEP_MODE     = 5'h07;
  localparam logic [4:0] TORQUE_LAST   = 5'h08;
  localparam logic [4:0] VELOCITY_LAST = 5'h12;
  // Node ID and IP table
  localparam logic [7:0]  NODE_MIN      = 8'h01;
  localparam logic [7:0]  NODE_MAX      = 8'h7F;
  localparam logic [6:0]  NODE_RST      = 7'h01;
  localparam logic [7:0]  IP_IDX_MAX    = 8'h0F;
  localparam logic [6:0]  IP_IDX_RST    = 7'h00;
  localparam logic [3:0]  IP_IDX_FIXED  = 4'h0;
  localparam logic [3:0]  IP_IDX_DHCP   = 4'hF;
  localparam logic [3:0]  IP_NET1_LAST  = 4'h3;
  localparam logic [31:0] IP_FIXED      = 32'h0A0A0A0A;
  localparam logic [31:0] IP_DHCP       = 32'h00000000;
  localparam logic [23:0] IP_NET1       = 24'hC0A801;
  localparam logic [23:0] IP_NET0       = 24'hC0A800;
  localparam logic [7:0]  IP_STEP       = 8'h0A;
  // Condition code bits
  localparam int COND_GT = 0;
  localparam int COND_EQ = 1;
  localparam int COND_LT = 2;
  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR  = 1;
  localparam int IRQ_PEAK = 2;
  localparam int IRQ_MODE = 3;
  localparam int IRQ_W    = 4;
  // Currents
  localparam int         CUR_W     = 8;
  localparam logic [7:0] PEAK_RST  = 8'h00;
  localparam logic [7:0] CONT_RST  = 8'h00;
  // Timing
  localparam int CLK_PERIOD_NS    = 50;
  localparam int TICK_NS          = 1000000;
  localparam int TICK_MS          = 1;
  localparam int PEAK_TIME_MS     = 1000;
  localparam int TICK_CYCLES_DFLT = TICK_NS / CLK_PERIOD_NS;
  localparam int PEAK_TICKS       = PEAK_TIME_MS / TICK_MS;

  typedef enum logic [1:0] {CLS_TORQUE, CLS_STEP, CLS_VELOCITY, CLS_POSITION} dcc_class_t;

  function automatic dcc_class_t dcc_class_of(input logic [4:0] m);
    if (m == STEP_MODE) return CLS_STEP;
    if (m <= TORQUE_LAST) return CLS_TORQUE;
    if (m <= VELOCITY_LAST) return CLS_VELOCITY;
    return CLS_POSITION;
  endfunction
endpackage
`default_nettype wire

// *** hdl/dcc_cur_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface dcc_cur_if #(parameter int W = 8);
  logic         tick;
  logic [W-1:0] demand;
  logic [W-1:0] peak;
  logic [W-1:0] cont;
  logic         limit;
  logic         expired;
  modport ctrl  (output tick, demand, peak, cont, input limit, expired);
  modport timer (input tick, demand, peak, cont, output limit, expired);
endinterface
`default_nettype wire

// *** hdl/dcc_peak_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcc_peak_timer #(
  parameter int W          = dcc_pkg::CUR_W,
  parameter int PEAK_TICKS = dcc_pkg::PEAK_TICKS
) (
  // Clock and reset
  input  wire logic   clk_in,
  input  wire logic   reset_n_in,
  // Current path
  dcc_cur_if.timer    cur
);
  localparam int SQ_W = 2 * W;

  logic [W-1:0]    dem_clip;
  logic [SQ_W-1:0] dem_sq;
  logic [SQ_W-1:0] cont_sq;
  logic [SQ_W-1:0] peak_sq;
  logic [31:0]     budget;
  logic [31:0]     rise;
  logic [31:0]     fall;
  logic [31:0]     acc_ff;
  logic [31:0]     nxt_acc;
  logic            limit_ff;
  logic            expired_ff;
  logic            over;
  logic            hit;

  assign dem_clip = (cur.demand > cur.peak) ? cur.peak : cur.demand;
  assign dem_sq   = SQ_W'(dem_clip) * SQ_W'(dem_clip);
  assign cont_sq  = SQ_W'(cur.cont) * SQ_W'(cur.cont);
  assign peak_sq  = SQ_W'(cur.peak) * SQ_W'(cur.peak);
  assign over     = dem_clip > cur.cont;
  // Heat budget equals one full second spent at peak demand
  assign budget   = 32'((peak_sq > cont_sq) ? (peak_sq - cont_sq) : '0) * 32'(PEAK_TICKS);
  assign rise     = 32'(dem_sq - cont_sq);
  assign fall     = 32'(cont_sq - dem_sq);
  // Integrate I squared above the continuous level, cool off below it
  assign nxt_acc  = over ? (limit_ff ? acc_ff : acc_ff + rise)
                         : ((acc_ff > fall) ? acc_ff - fall : '0);
  assign hit      = cur.tick && over && !limit_ff && (nxt_acc >= budget);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_ff     <= '0;
      limit_ff   <= 1'b0;
      expired_ff <= 1'b0;
    end else begin
      if (cur.tick) acc_ff <= nxt_acc;
      if (hit) limit_ff <= 1'b1;
      else if (cur.tick && nxt_acc == '0) limit_ff <= 1'b0;
      expired_ff <= hit;
    end
  end

  assign cur.limit   = limit_ff;
  assign cur.expired = expired_ff;

  a_expire_limits: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    expired_ff |-> limit_ff && $past(over) && $past(cur.tick))
    else $error("Peak expiry without limit or demand");
  a_limit_release: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $fell(limit_ff) |-> $past(cur.tick) && acc_ff == '0)
    else $error("Peak limit released with heat left");
endmodule
`default_nettype wire

// *** hdl/dcc_drive_cmd.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Each change of the mode select input swaps the active mode between stored secondary and primary.
// - Primary mode is a separate setting written only by the primary mode command.
// - Codes 1-8 torque variants, code 7 step and direction.
// - Codes 10-18 velocity: jog, analog, run/stop, speed select, preset speed.
// - Code 21 is point-to-point, code 22 analog position.
// - Secondary mode accepts 1 to 22 and resets to 7.
// - Query of secondary mode answers command, equals sign and stored value.
// - Fieldbus units accept node ID 1 to 127, default 1.
// - Ethernet units accept IP table index 0 to 15, default 0.
// - IP table: 10.10.10.10, 192.168.1.x, 192.168.0.x, then 0.0.0.0 for DHCP.
// - Peak time is an I squared t integral above continuous current.
// - Peak current lasts at most one second, then limit drops to continuous.
// - Register compare tests first data register against second into condition codes.
// - Greater-than flag is set when the first register is larger.
// - Jump if greater goes to given line when set, else next line.
module dcc_drive_cmd #(
  parameter int TICK_CYCLES = dcc_pkg::TICK_CYCLES_DFLT,
  parameter int PEAK_TICKS  = dcc_pkg::PEAK_TICKS,
  parameter bit IS_ETHERNET = 1'b0
) (
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              reset_n_in,
  // Wishbone slave
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [7:0]        wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic      [31:0]       wb_dat_out,
  output logic                   wb_ack_out,
  output logic                   irq_out,
  // Drive side
  input  wire logic              mode_select_input_in,
  input  wire logic [7:0]        current_demand_in,
  output logic      [4:0]        active_mode_out,
  output var dcc_pkg::dcc_class_t mode_class_out,
  output logic                   use_secondary_out,
  output logic      [7:0]        current_limit_out,
  output logic                   peak_limited_out,
  output logic      [6:0]        node_id_out,
  output logic      [31:0]       ip_addr_out,
  output logic      [7:0]        pc_out
);
  localparam int TW = $clog2(TICK_CYCLES);

  logic [31:0]               dreg_ff [dcc_pkg::N_DREG];
  logic                      ack_ff;
  logic [31:0]               dat_ff;
  logic [31:0]               resp_ff;
  logic [4:0]                sec_ff;
  logic [4:0]                pri_ff;
  logic [6:0]                node_ff;
  logic [7:0]                peak_ff;
  logic [7:0]                cont_ff;
  logic [2:0]                cond_ff;
  logic [7:0]                pc_ff;
  logic                      use_sec_ff;
  logic                      msel_prev_ff;
  logic                      msel_seen_ff;
  logic [dcc_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [dcc_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [dcc_pkg::IRQ_W-1:0] nxt_irq_stat;
  logic                      irq_ff;
  logic [4:0]                active_ff;
  dcc_pkg::dcc_class_t       class_ff;
  logic [7:0]                limit_ff;
  logic                      limited_ff;
  logic [31:0]               ip_ff;
  logic [TW-1:0]             tick_cnt_ff;
  logic                      tick_ff;

  dcc_cur_if #(.W(dcc_pkg::CUR_W)) cur ();

  // Bus decode
  wire        req      = wb_cyc_in && wb_stb_in;
  wire        wr_acc   = req && ack_ff && wb_we_in;
  wire [31:0] bmask    = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  wire        d_hit    = (wb_adr_in & dcc_pkg::DATA_MASK) == dcc_pkg::REG_DATA;
  wire [2:0]  d_idx    = wb_adr_in[4:2];
  wire        d_wr     = wr_acc && d_hit;
  wire        wr_mask  = wr_acc && wb_adr_in == dcc_pkg::REG_IRQ_MASK;
  wire        wr_clr   = wr_acc && wb_adr_in == dcc_pkg::REG_IRQ_STAT;
  // Commands must be written as a whole word so that code and parameters arrive together
  wire        wr_cmd   = wr_acc && wb_adr_in == dcc_pkg::REG_CMD && (&wb_sel_in);

  // Command word fields
  wire [2:0]  c_code   = wb_dat_in[dcc_pkg::CMD_CODE_LSB +: 3];
  wire        c_has    = wb_dat_in[dcc_pkg::CMD_HAS_BIT];
  wire [7:0]  c_p1     = wb_dat_in[dcc_pkg::CMD_P1_LSB +: 8];
  wire [7:0]  c_p2     = wb_dat_in[dcc_pkg::CMD_P2_LSB +: 8];
  wire        is_sec   = c_code == dcc_pkg::CMD_SEC;
  wire        is_pri   = c_code == dcc_pkg::CMD_PRI;
  wire        is_node  = c_code == dcc_pkg::CMD_NODE;
  wire        is_peak  = c_code == dcc_pkg::CMD_PEAK;
  wire        is_cont  = c_code == dcc_pkg::CMD_CONT;
  wire        is_cmp   = c_code == dcc_pkg::CMD_CMP;
  wire        is_jump  = c_code == dcc_pkg::CMD_JUMP;
  wire        mode_ok  = c_p1 >= dcc_pkg::MODE_MIN && c_p1 <= dcc_pkg::MODE_MAX;
  wire        node_ok  = IS_ETHERNET ? (c_p1 <= dcc_pkg::IP_IDX_MAX)
                                     : (c_p1 >= dcc_pkg::NODE_MIN && c_p1 <= dcc_pkg::NODE_MAX);
  wire        reg_ok   = c_p1 < 8'(dcc_pkg::N_DREG) && c_p2 < 8'(dcc_pkg::N_DREG);
  // A command without parameter is a query; compare and jump cannot be queried
  wire        cmd_ok   = (is_sec || is_pri) ? (!c_has || mode_ok) :
                         is_node ? (!c_has || node_ok) :
                         (is_peak || is_cont) ? 1'b1 :
                         (is_cmp || is_jump) ? (c_has && (is_jump || reg_ok)) : 1'b0;
  wire        do_set   = wr_cmd && cmd_ok && c_has;
  wire        do_query = wr_cmd && cmd_ok && !c_has && !is_cmp && !is_jump;
  wire [15:0] q_val    = is_sec ? 16'(sec_ff) : is_pri ? 16'(pri_ff) : is_node ? 16'(node_ff) :
                         is_peak ? 16'(peak_ff) : 16'(cont_ff);

  // Register compare
  wire signed [31:0] cmp_a = dreg_ff[c_p1[2:0]];
  wire signed [31:0] cmp_b = dreg_ff[c_p2[2:0]];
  wire [2:0]  nxt_cond = {cmp_a < cmp_b, cmp_a == cmp_b, cmp_a > cmp_b};

  // Mode select edge
  wire        msel_chg = msel_seen_ff && (mode_select_input_in != msel_prev_ff);

  // IP table lookup
  wire [3:0]  ip_idx   = node_ff[3:0];
  wire [7:0]  host_oct = 8'(ip_idx * dcc_pkg::IP_STEP);
  wire [31:0] ip_w     = !IS_ETHERNET ? 32'h00000000 :
                         ip_idx == dcc_pkg::IP_IDX_FIXED ? dcc_pkg::IP_FIXED :
                         ip_idx == dcc_pkg::IP_IDX_DHCP ? dcc_pkg::IP_DHCP :
                         {(ip_idx <= dcc_pkg::IP_NET1_LAST) ? dcc_pkg::IP_NET1 : dcc_pkg::IP_NET0,
                          host_oct};

  // Read mux
  wire [31:0] stat_w   = {2'h0, 2'(class_ff), limited_ff, cond_ff, 2'h0, use_sec_ff, active_ff,
                          3'h0, pri_ff, 3'h0, sec_ff};
  wire [31:0] rd_w     = d_hit ? dreg_ff[d_idx] :
                         wb_adr_in == dcc_pkg::REG_RESP ? resp_ff :
                         wb_adr_in == dcc_pkg::REG_STAT ? stat_w :
                         wb_adr_in == dcc_pkg::REG_IRQ_STAT ? 32'(irq_stat_ff) :
                         wb_adr_in == dcc_pkg::REG_IRQ_MASK ? 32'(irq_mask_ff) :
                         wb_adr_in == dcc_pkg::REG_IP ? ip_ff :
                         wb_adr_in == dcc_pkg::REG_CUR ? {16'h0000, peak_ff, cont_ff} :
                         wb_adr_in == dcc_pkg::REG_PC ? {24'h000000, pc_ff} : 32'h00000000;

  // Interrupt status: a new event wins over a clear in the same cycle
  wire [dcc_pkg::IRQ_W-1:0] irq_set = {msel_chg, cur.expired, wr_cmd && !cmd_ok, wr_cmd && cmd_ok};
  wire [dcc_pkg::IRQ_W-1:0] irq_clr = wr_clr ? wb_dat_in[dcc_pkg::IRQ_W-1:0] & bmask[dcc_pkg::IRQ_W-1:0]
                                             : '0;
  assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;

  // Millisecond tick for the heat integrator
  wire        tick_wrap = tick_cnt_ff == TW'(TICK_CYCLES - 1);

  assign cur.tick   = tick_ff;
  assign cur.demand = current_demand_in;
  assign cur.peak   = peak_ff;
  assign cur.cont   = cont_ff;

  dcc_peak_timer #(.W(dcc_pkg::CUR_W), .PEAK_TICKS(PEAK_TICKS)) u_timer (
    .clk_in     (sys_clk_in),
    .reset_n_in (reset_n_in),
    .cur        (cur)
  );

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
    end else begin
      ack_ff <= req && !ack_ff;
      if (req && !ack_ff) dat_ff <= rd_w;
    end
  end

  generate
    for (genvar i = 0; i < dcc_pkg::N_DREG; i++) begin : g_dreg
      always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) dreg_ff[i] <= '0;
        else if (d_wr && d_idx == 3'(i)) dreg_ff[i] <= (dreg_ff[i] & ~bmask) | (wb_dat_in & bmask);
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sec_ff  <= dcc_pkg::SEC_MODE_RST;
      pri_ff  <= dcc_pkg::PRI_MODE_RST;
      node_ff <= IS_ETHERNET ? dcc_pkg::IP_IDX_RST : dcc_pkg::NODE_RST;
    end else if (do_set) begin
      if (is_sec) sec_ff <= c_p1[4:0];
      if (is_pri) pri_ff <= c_p1[4:0];
      if (is_node) node_ff <= c_p1[6:0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      peak_ff <= dcc_pkg::PEAK_RST;
      cont_ff <= dcc_pkg::CONT_RST;
      resp_ff <= '0;
    end else begin
      if (do_set && is_peak) peak_ff <= c_p1;
      if (do_set && is_cont) cont_ff <= c_p1;
      if (do_query) resp_ff <= {5'h00, c_code, dcc_pkg::RESP_EQ, q_val};
    end
  end

  // Compare and conditional jump feed the program sequencer
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cond_ff <= '0;
      pc_ff   <= '0;
    end else if (do_set) begin
      if (is_cmp) cond_ff <= nxt_cond;
      if (is_jump) pc_ff <= cond_ff[dcc_pkg::COND_GT] ? c_p1 : pc_ff + 8'h01;
    end
  end

  // Input level at reset release is the reference, not a change
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      msel_prev_ff <= 1'b0;
      msel_seen_ff <= 1'b0;
      use_sec_ff   <= 1'b0;
    end else begin
      msel_prev_ff <= mode_select_input_in;
      msel_seen_ff <= 1'b1;
      if (msel_chg) use_sec_ff <= !use_sec_ff;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff      <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr_mask) irq_mask_ff <= (irq_mask_ff & ~bmask[dcc_pkg::IRQ_W-1:0])
                                | (wb_dat_in[dcc_pkg::IRQ_W-1:0] & bmask[dcc_pkg::IRQ_W-1:0]);
      irq_ff <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else begin
      tick_cnt_ff <= tick_wrap ? '0 : tick_cnt_ff + 1'b1;
      tick_ff     <= tick_wrap;
    end
  end

  // Active mode, current limit, limit flag and IP address lag their settings by one cycle; the mode class lags by two
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      active_ff  <= dcc_pkg::PRI_MODE_RST;
      class_ff   <= dcc_pkg::CLS_STEP;
      limit_ff   <= dcc_pkg::PEAK_RST;
      limited_ff <= 1'b0;
      ip_ff      <= '0;
    end else begin
      active_ff  <= use_sec_ff ? sec_ff : pri_ff;
      class_ff   <= dcc_pkg::dcc_class_of(active_ff);
      limit_ff   <= cur.limit ? cont_ff : peak_ff;
      limited_ff <= cur.limit;
      ip_ff      <= ip_w;
    end
  end

  assign wb_ack_out        = ack_ff;
  assign wb_dat_out        = dat_ff;
  assign irq_out           = irq_ff;
  assign active_mode_out   = active_ff;
  assign mode_class_out    = class_ff;
  assign use_secondary_out = use_sec_ff;
  assign current_limit_out = limit_ff;
  assign peak_limited_out  = limited_ff;
  assign node_id_out       = node_ff;
  assign ip_addr_out       = ip_ff;
  assign pc_out            = pc_ff;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_cmp_cmd;
    do_set && is_cmp;
  endsequence
  sequence s_jump_cmd;
    do_set && is_jump;
  endsequence

  a_ack_single: assert property (ack_ff |=> !ack_ff)
    else $error("Bus acknowledge held longer than one cycle");
  a_mode_toggle: assert property (msel_chg |=> use_sec_ff != $past(use_sec_ff) ##1 active_ff ==
    ($past(use_sec_ff) ? $past(sec_ff) : $past(pri_ff)))
    else $error("Mode select change did not swap active mode");
  a_pri_kept: assert property (!(do_set && is_pri) |=> $stable(pri_ff))
    else $error("Primary mode changed by another command");
  a_sec_range: assert property (sec_ff >= 5'(dcc_pkg::MODE_MIN) && sec_ff <= 5'(dcc_pkg::MODE_MAX))
    else $error("Secondary mode out of range");
  a_class_map: assert property (class_ff == dcc_pkg::CLS_STEP |-> $past(active_ff) == dcc_pkg::STEP_MODE)
    else $error("Step class without step mode");
  a_query_resp: assert property (do_query && is_sec |=> resp_ff[15:0] == 16'($past(sec_ff))
    && resp_ff[23:16] == dcc_pkg::RESP_EQ)
    else $error("Secondary mode query answered wrongly");
  a_node_range: assert property (IS_ETHERNET ? node_ff <= 7'(dcc_pkg::IP_IDX_MAX) : node_ff != 7'h00)
    else $error("Node identifier out of range");
  a_ip_table: assert property (IS_ETHERNET && $stable(node_ff) && node_ff == 7'h04 |=>
    ip_addr_out == 32'hC0A80028)
    else $error("IP table entry four wrong");
  a_gt_flag: assert property (s_cmp_cmd |=> cond_ff[dcc_pkg::COND_GT] == ($past(cmp_a) > $past(cmp_b)))
    else $error("Greater-than flag does not match compare");
  a_jump_target: assert property (s_jump_cmd |=> pc_ff == ($past(cond_ff[dcc_pkg::COND_GT]) ?
    $past(c_p1) : $past(pc_ff) + 8'h01))
    else $error("Conditional jump went to wrong line");
  a_limit_cont: assert property (cur.limit && $stable(cont_ff) |=> current_limit_out == $past(cont_ff))
    else $error("Current limit not at continuous level after expiry");
  a_bad_query: assert property (wr_cmd && !c_has && (is_cmp || is_jump) |=> irq_stat_ff[dcc_pkg::IRQ_ERR])
    else $error("Write-only command without parameter not refused");
endmodule
`default_nettype wire

// *** bench/dcc_drive_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcc_drive_model (
  // Control from the bench
  input  wire logic       clk_in,
  input  wire logic       toggle_in,
  input  wire logic [7:0] level_in,
  // Drive side pins
  output logic            mode_sel_out,
  output logic [7:0]      demand_out
);
  initial mode_sel_out = 1'b0;
  initial demand_out = 8'h00;
  // Pins move only just after a rising edge, like a real drive front end
  always @(posedge clk_in) begin
    if (toggle_in) begin
      mode_sel_out <= ~mode_sel_out;
    end
    demand_out <= level_in;
  end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, tog = 1'b0;
  logic [7:0]  adr = 8'h00, lvl = 8'h00, dem, lim, pc;
  logic [31:0] wdat = 32'h00000000, dat_o, ip, ip_e, a, b;
  logic        ack, irq, msel, usec, lim_f, gt;
  logic [4:0]  am;
  logic [6:0]  nid, nid_e;
  logic [63:0] e;
  logic [63:0] expq[$];
  dcc_pkg::dcc_class_t cls;
  int n_mismatch = 0, samples_checked = 0, m, i, v, n, s, p;
  always #25 clk = ~clk;
  dcc_drive_model model (.clk_in(clk), .toggle_in(tog), .level_in(lvl), .mode_sel_out(msel), .demand_out(dem));
  // Short tick and budget keep the peak scenario to a few dozen cycles
  dcc_drive_cmd #(.TICK_CYCLES(4), .PEAK_TICKS(5), .IS_ETHERNET(1'b0)) dut (
    .sys_clk_in(clk), .reset_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(dat_o), .wb_ack_out(ack),
    .irq_out(irq), .mode_select_input_in(msel), .current_demand_in(dem), .active_mode_out(am),
    .mode_class_out(cls), .use_secondary_out(usec), .current_limit_out(lim),
    .peak_limited_out(lim_f), .node_id_out(nid), .ip_addr_out(ip), .pc_out(pc));
  // Ethernet variant follows the same bus; only its index and address are watched
  dcc_drive_cmd #(.TICK_CYCLES(4), .PEAK_TICKS(5), .IS_ETHERNET(1'b1)) dut_eth (
    .sys_clk_in(clk), .reset_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(), .wb_ack_out(),
    .irq_out(), .mode_select_input_in(msel), .current_demand_in(dem), .active_mode_out(),
    .mode_class_out(), .use_secondary_out(), .current_limit_out(), .peak_limited_out(),
    .node_id_out(nid_e), .ip_addr_out(ip_e), .pc_out());
  task automatic tally_and_finish();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Read data is judged where it appears, against the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
      e = expq.pop_front();
      chk("read data", dat_o & e[63:32], e[31:0]);
    end
  end
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_mismatch++;
      tally_and_finish();
    end
    cyc <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] ad, input logic [31:0] exp, input logic [31:0] mask);
    expq.push_back({mask, exp});
    bus(1'b0, ad, 32'h00000000);
  endtask
  task automatic cmd(input logic [2:0] c, input logic h, input logic [7:0] p1, input logic [7:0] p2);
    bus(1'b1, dcc_pkg::REG_CMD, {8'h00, p2, p1, 4'h0, h, c});
    repeat (2) @(posedge clk);
  endtask
  task automatic tog_mode();
    tog <= 1'b1;
    @(posedge clk);
    tog <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic wait_lim(input logic lv);
    int k;
    k = 0;
    while (lim_f !== lv && k < 200) begin
      @(posedge clk);
      k++;
    end
    if (k >= 200) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  function automatic logic [31:0] ipx(input int k);
    return (k == 0) ? 32'h0A0A0A0A : (k == 15) ? 32'h00000000 :
           {((k <= 3) ? 24'hC0A801 : 24'hC0A800), 8'(k * 10)};
  endfunction
  function automatic logic [31:0] cl(input int md);
    return (md == 7) ? 32'h1 : (md <= 8) ? 32'h0 : (md <= 18) ? 32'h2 : 32'h3;
  endfunction
  initial begin
    void'($urandom(29825));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdx(dcc_pkg::REG_STAT, 32'h00070707, 32'h003F1F1F);
    rdx(8'h40, 32'h00000000, 32'hFFFFFFFF);
    chk("node id", {25'h0, nid}, 32'h1);
    chk("ip address", ip, 32'h00000000);
    chk("eth index", {25'h0, nid_e}, 32'h0);
    chk("eth ip address", ip_e, 32'h0A0A0A0A);
    s = 7;
    for (m = 0; m <= 23; m++) begin
      cmd(3'h1, 1'b1, m[7:0], 8'h00);
      if (m >= 1 && m <= 22) s = m;
      rdx(dcc_pkg::REG_STAT, s, 32'h0000001F);
      if (m >= 1 && m <= 22) begin
        cmd(3'h1, 1'b0, 8'h00, 8'h00);
        rdx(dcc_pkg::REG_RESP, 32'h013D0000 | m, 32'hFFFFFFFF);
        tog_mode();
        chk("active mode", {27'h0, am}, m);
        chk("use secondary", {31'h0, usec}, 32'h1);
        chk("mode class", {30'h0, cls}, cl(m));
        tog_mode();
        chk("active mode", {27'h0, am}, 32'h7);
      end
    end
    cmd(3'h2, 1'b1, 8'h05, 8'h00);
    rdx(dcc_pkg::REG_STAT, 32'h00000516, 32'h00001F1F);
    n = 1;
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 0 : (i == 1) ? 128 : (i == 2) ? 127 : $urandom_range(126, 1);
      if (v >= 1 && v <= 127) n = v;
      cmd(3'h3, 1'b1, v[7:0], 8'h00);
      chk("node id", {25'h0, nid}, n);
    end
    for (i = 0; i <= 16; i++) begin
      cmd(3'h3, 1'b1, i[7:0], 8'h00);
      chk("eth index", {25'h0, nid_e}, (i > 15) ? 15 : i);
      chk("eth ip address", ip_e, ipx((i > 15) ? 15 : i));
    end
    p = 0;
    for (i = 0; i < 6; i++) begin
      a = $urandom;
      b = (i == 0) ? a : $urandom;
      bus(1'b1, 8'h20, a);
      bus(1'b1, 8'h24, b);
      cmd(3'h6, 1'b1, 8'h00, 8'h01);
      gt = $signed(a) > $signed(b);
      rdx(dcc_pkg::REG_STAT, {5'h0, gt ? 3'h1 : (a == b) ? 3'h2 : 3'h4, 24'h0}, 32'h07000000);
      cmd(3'h7, 1'b1, 8'(i + 40), 8'h00);
      p = gt ? i + 40 : p + 1;
      chk("pc", {24'h0, pc}, p);
    end
    bus(1'b1, dcc_pkg::REG_IRQ_STAT, 32'h2);
    cmd(3'h7, 1'b0, 8'h00, 8'h00);
    chk("pc", {24'h0, pc}, p);
    rdx(dcc_pkg::REG_IRQ_STAT, 32'h2, 32'h2);
    cmd(3'h5, 1'b1, 8'h64, 8'h00);
    cmd(3'h4, 1'b1, 8'hC8, 8'h00);
    lvl <= 8'hC8;
    repeat (12) @(posedge clk);
    chk("limited", {31'h0, lim_f}, 32'h0);
    chk("limit", {24'h0, lim}, 32'hC8);
    wait_lim(1'b1);
    repeat (2) @(posedge clk);
    chk("limited", {31'h0, lim_f}, 32'h1);
    chk("limit", {24'h0, lim}, 32'h64);
    lvl <= 8'h00;
    rdx(dcc_pkg::REG_IRQ_STAT, 32'h4, 32'h4);
    chk("irq", {31'h0, irq}, 32'h0);
    bus(1'b1, dcc_pkg::REG_IRQ_MASK, 32'h4);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, dcc_pkg::REG_IRQ_STAT, 32'h4);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    wait_lim(1'b0);
    chk("limited", {31'h0, lim_f}, 32'h0);
    chk("limit", {24'h0, lim}, 32'hC8);
    tally_and_finish();
  end
endmodule
`default_nettype wire
